/* File: src/mac_acc_pair.sv */
// Two 40-bit accumulators held in a small registered memory
module mac_acc_pair (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic writeEn,
    input wire logic writeSel,
    input wire logic [mac_pkg::ACC_W-1:0] writeData,
    output logic [mac_pkg::ACC_W-1:0] productAcc,
    output logic [mac_pkg::ACC_W-1:0] shiftAcc
);
    import mac_pkg::*;

    typedef struct packed {
        logic [ACC_W-1:0] prod;
        logic [ACC_W-1:0] shft;
    } pair_state_t;

    pair_state_t cur;
    pair_state_t next_cur;

    // ************************************************************
    // Storage update
    // ************************************************************
    // Write port selects one accumulator, written at the cycle end
    always_comb begin
        next_cur = cur;
        if (writeEn && !writeSel) begin
            next_cur.prod = writeData;
        end
        if (writeEn && writeSel) begin
            next_cur.shft = writeData;
        end
    end

    // Registered storage, read data straight from flops
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cur <= '{prod: ACC_RESET, shft: ACC_RESET};
        end else begin
            cur <= next_cur;
        end
    end

    assign productAcc = cur.prod;
    assign shiftAcc = cur.shft;
endmodule

/* File: src/mac_pkg.sv */
// Package: constants and types of the multiply-accumulate unit
package mac_pkg;

    // ************************************************************
    // Widths and field positions
    // ************************************************************
    localparam int ACC_W = 40;
    localparam int WORD_W = 16;
    localparam int TOP_W = 8;
    localparam int STAT_W = 16;
    localparam int PRODUCT_OVF_BIT = 6;
    localparam int SHIFT_OVF_BIT = 8;
    localparam int TOP_SIGN_BIT = 7;
    localparam int TOP_SEC_LSB = 32;
    localparam int MID_SEC_LSB = 16;
    localparam int ROUND_BIT = 15;

    // ************************************************************
    // Reset and clamp values
    // ************************************************************
    localparam logic [ACC_W-1:0] ACC_RESET = 40'h00_0000_0000;
    localparam logic [15:0] CLAMP_POS_TOP = 16'h0000;
    localparam logic [15:0] CLAMP_POS_MID = 16'h7FFF;
    localparam logic [15:0] CLAMP_POS_LOW = 16'hFFFF;
    localparam logic [15:0] CLAMP_NEG_TOP = 16'hFFFF;
    localparam logic [15:0] CLAMP_NEG_MID = 16'h8000;
    localparam logic [15:0] CLAMP_NEG_LOW = 16'h0000;

    // ************************************************************
    // Command, option and source encodings
    // ************************************************************
    typedef enum logic [3:0] {
        CMD_NOP,
        CMD_MUL,
        CMD_MAC_ADD,
        CMD_MAC_SUB,
        CMD_CLEAR,
        CMD_ROUND,
        CMD_CLAMP,
        CMD_MOVE_LOW,
        CMD_MOVE_MID,
        CMD_MOVE_TOP
    } mac_cmd_t;

    typedef enum logic [1:0] {
        SIGN_SS,
        SIGN_UU,
        SIGN_SU,
        SIGN_US
    } sign_opt_t;

    typedef enum logic [2:0] {
        XSRC_XIN0,
        XSRC_XIN1,
        XSRC_ALU,
        XSRC_PLOW,
        XSRC_PMID,
        XSRC_PTOP,
        XSRC_SMID,
        XSRC_STOP
    } xsrc_t;

    typedef enum logic [1:0] {
        YSRC_YIN0,
        YSRC_YIN1,
        YSRC_SMID,
        YSRC_XSQ
    } ysrc_t;

endpackage

/* File: src/mac_unit_result_saturation.sv */
// Multiply-accumulate datapath with clamp, round, clear and overflow status
// How it works
// - Clear zeroes all 40 bits of the chosen accumulator.
// - Clear forces both overflow bits low; conditional clear needs its condition.
// - Round alters only fractional results, same as multiply round option.
// - Product accumulator overflow sits in status bit 6.
// - Shift accumulator overflow sits in status bit 8.
// - Status updates at cycle end, visible next cycle.
// - Section moves leave overflow bits unchanged.
// - Adding zero product re-evaluates the target overflow bit.
// - Overflow set when top nine bits not all equal, else cleared.
// - Clamp tests real top nine bits, not the status flags.
// - Clamp without overflow keeps low words, sign-extends top eight bits.
// - Clamp overflow with top bit 7 low loads maximum positive value.
// - Clamp overflow with top bit 7 high loads maximum negative value.
// - Clamp acts only in its cycle; no persistent saturation mode.
// - Self-assign with round updates only that accumulator's overflow bit.
// - Multiply, add, subtract into either accumulator with round and sign options.
// - Two 16-bit operands, 32-bit product, 40-bit add or subtract.
// - Operand sources restricted in conditional forms; y may square x.
// - Read at cycle start, write at cycle end.
// - Sections are bits 0-15, 16-31, 32-39 with top sign extension.
// - Middle load sign-extends into top; low load touches nothing else.
// - Fractional mode shifts every product left by one.
// - Sign options pick signed or unsigned for each operand.
module mac_unit_result_saturation (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cmdValid,
    input wire mac_pkg::mac_cmd_t cmd,
    input wire logic condTrue,
    input wire logic destShift,
    input wire logic roundEn,
    input wire mac_pkg::sign_opt_t signOpt,
    input wire logic fracMode,
    input wire logic restrictedForm,
    input wire mac_pkg::xsrc_t xSel,
    input wire mac_pkg::ysrc_t ySel,
    input wire logic [mac_pkg::WORD_W-1:0] dregX,
    input wire logic [mac_pkg::WORD_W-1:0] dregY,
    input wire logic [mac_pkg::WORD_W-1:0] x_input_reg_0,
    input wire logic [mac_pkg::WORD_W-1:0] x_input_reg_1,
    input wire logic [mac_pkg::WORD_W-1:0] y_input_reg_0,
    input wire logic [mac_pkg::WORD_W-1:0] y_input_reg_1,
    input wire logic [mac_pkg::WORD_W-1:0] alu_result_reg,
    input wire logic [mac_pkg::WORD_W-1:0] moveData,
    output logic [mac_pkg::ACC_W-1:0] product_accumulator,
    output logic [mac_pkg::ACC_W-1:0] shift_result_accumulator,
    output logic [mac_pkg::STAT_W-1:0] arith_status_register,
    output logic product_acc_overflow_flag,
    output logic shift_acc_overflow_flag,
    output logic cmdDone
);
    import mac_pkg::*;

    // ************************************************************
    // Helper functions
    // ************************************************************
    // Overflow exists when the top nine bits are not all equal
    function automatic logic topNineOvf(input logic [ACC_W-1:0] v);
        topNineOvf = !((&v[ACC_W-1:ACC_W-9]) || !(|v[ACC_W-1:ACC_W-9]));
    endfunction

    // Round a fractional accumulator at the middle-word boundary
    function automatic logic [ACC_W-1:0] roundAcc(input logic [ACC_W-1:0] v,
                                                  input logic frac);
        logic [ACC_W-1:0] r;
        r = v + (ACC_W'(1) << ROUND_BIT);
        r[ROUND_BIT:0] = '0;
        roundAcc = frac ? r : v;
    endfunction

    // Extend one operand to 17 bits, signed or unsigned
    function automatic logic signed [WORD_W:0] extOp(input logic [WORD_W-1:0] v,
                                                     input logic sgn);
        extOp = {sgn & v[WORD_W-1], v};
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic ovfProd;
        logic ovfShift;
        logic done;
    } mac_state_t;

    mac_state_t cur;
    mac_state_t next_cur;

    logic [ACC_W-1:0] accProd;
    logic [ACC_W-1:0] accShift;
    logic [ACC_W-1:0] accSel;
    logic [ACC_W-1:0] accNew;
    logic accWrite;
    logic [WORD_W-1:0] xOp;
    logic [WORD_W-1:0] yOp;
    logic signed [WORD_W:0] xExt;
    logic signed [WORD_W:0] yExt;
    logic signed [2*WORD_W+1:0] prodFull;
    logic [ACC_W-1:0] prodAcc;
    logic [ACC_W-1:0] sum;
    logic go;
    logic newOvf;
    logic ovfUpdate;
    logic clampOvf;

    // ************************************************************
    // Operand selection
    // ************************************************************
    // Restricted forms read only the allowed x and y sources
    always_comb begin
        if (restrictedForm) begin
            unique case (xSel)
                XSRC_XIN0: xOp = x_input_reg_0;
                XSRC_XIN1: xOp = x_input_reg_1;
                XSRC_ALU: xOp = alu_result_reg;
                XSRC_PLOW: xOp = accProd[MID_SEC_LSB-1:0];
                XSRC_PMID: xOp = accProd[TOP_SEC_LSB-1:MID_SEC_LSB];
                XSRC_PTOP: xOp = {{TOP_W{accProd[ACC_W-1]}}, accProd[ACC_W-1:TOP_SEC_LSB]};
                XSRC_SMID: xOp = accShift[TOP_SEC_LSB-1:MID_SEC_LSB];
                XSRC_STOP: xOp = {{TOP_W{accShift[ACC_W-1]}}, accShift[ACC_W-1:TOP_SEC_LSB]};
            endcase
            unique case (ySel)
                YSRC_YIN0: yOp = y_input_reg_0;
                YSRC_YIN1: yOp = y_input_reg_1;
                YSRC_SMID: yOp = accShift[TOP_SEC_LSB-1:MID_SEC_LSB];
                YSRC_XSQ: yOp = xOp; // Squaring path
            endcase
        end else begin
            xOp = dregX;
            yOp = dregY;
        end
    end

    // ************************************************************
    // Multiplier and adder/subtracter
    // ************************************************************
    // Signed 17x17 product; fractional mode drops the redundant sign bit
    always_comb begin
        xExt = extOp(xOp, (signOpt == SIGN_SS) || (signOpt == SIGN_SU));
        yExt = extOp(yOp, (signOpt == SIGN_SS) || (signOpt == SIGN_US));
        prodFull = xExt * yExt;
        prodAcc = ACC_W'(prodFull); // Sign-extended into 40 bits
        if (fracMode) begin
            prodAcc = prodAcc << 1;
        end
    end

    // Current accumulator is read at cycle start
    assign accSel = destShift ? accShift : accProd;
    assign go = cmdValid && condTrue;

    // ************************************************************
    // Result and status computation
    // ************************************************************
    // Selects the new accumulator value and the overflow update
    always_comb begin
        next_cur = cur;
        next_cur.done = go;
        accNew = accSel;
        accWrite = 1'b0;
        ovfUpdate = 1'b0;
        newOvf = 1'b0;
        clampOvf = topNineOvf(accSel);
        sum = accSel;
        if (go) begin
            unique case (cmd)
                CMD_MUL, CMD_MAC_ADD, CMD_MAC_SUB: begin
                    if (cmd == CMD_MUL) begin
                        sum = prodAcc;
                    end else if (cmd == CMD_MAC_ADD) begin
                        sum = accSel + prodAcc; // Wraps
                    end else begin
                        sum = accSel - prodAcc;
                    end
                    accNew = roundEn ? roundAcc(sum, fracMode) : sum;
                    accWrite = 1'b1;
                    ovfUpdate = 1'b1;
                    newOvf = topNineOvf(accNew);
                end
                CMD_CLEAR: begin
                    accNew = ACC_RESET;
                    accWrite = 1'b1;
                    next_cur.ovfProd = 1'b0;
                    next_cur.ovfShift = 1'b0;
                end
                CMD_ROUND: begin
                    // Self-assignment, optional round, own flag only
                    accNew = roundEn ? roundAcc(accSel, fracMode) : accSel;
                    accWrite = 1'b1;
                    ovfUpdate = 1'b1;
                    newOvf = topNineOvf(accNew);
                end
                CMD_CLAMP: begin
                    // One-shot clamp, flags untouched
                    if (!clampOvf) begin
                        accNew = {{TOP_W{accSel[TOP_SEC_LSB-1]}},
                                  accSel[TOP_SEC_LSB-1:0]};
                    end else if (!accSel[TOP_SEC_LSB+TOP_SIGN_BIT]) begin
                        accNew = {CLAMP_POS_TOP[TOP_W-1:0], CLAMP_POS_MID,
                                  CLAMP_POS_LOW};
                    end else begin
                        accNew = {CLAMP_NEG_TOP[TOP_W-1:0], CLAMP_NEG_MID,
                                  CLAMP_NEG_LOW};
                    end
                    accWrite = 1'b1;
                end
                CMD_MOVE_LOW: begin
                    accNew = {accSel[ACC_W-1:MID_SEC_LSB], moveData};
                    accWrite = 1'b1; // Flags unchanged
                end
                CMD_MOVE_MID: begin
                    accNew = {{TOP_W{moveData[WORD_W-1]}}, moveData,
                              accSel[MID_SEC_LSB-1:0]};
                    accWrite = 1'b1;
                end
                CMD_MOVE_TOP: begin
                    accNew = {moveData[TOP_W-1:0], accSel[TOP_SEC_LSB-1:0]};
                    accWrite = 1'b1;
                end
                default: begin
                    accWrite = 1'b0;
                end
            endcase
        end
        if (ovfUpdate) begin
            if (destShift) begin
                next_cur.ovfShift = newOvf;
            end else begin
                next_cur.ovfProd = newOvf;
            end
        end
    end

    // ************************************************************
    // Accumulator storage
    // ************************************************************
    mac_acc_pair accStore (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .writeEn(accWrite),
        .writeSel(destShift),
        .writeData(accNew),
        .productAcc(accProd),
        .shiftAcc(accShift)
    );

    // Status flops update at cycle end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cur <= '{ovfProd: 1'b0, ovfShift: 1'b0, done: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Status word carries both flags at their fixed positions
    always_comb begin
        arith_status_register = '0;
        arith_status_register[PRODUCT_OVF_BIT] = cur.ovfProd;
        arith_status_register[SHIFT_OVF_BIT] = cur.ovfShift;
    end

    assign product_accumulator = accProd;
    assign shift_result_accumulator = accShift;
    assign product_acc_overflow_flag = cur.ovfProd;
    assign shift_acc_overflow_flag = cur.ovfShift;
    assign cmdDone = cur.done;
endmodule

/* File: verif/mac_unit_result_saturation_assertions.sv */
// Checker of port relations of the multiply-accumulate unit
module mac_unit_result_saturation_assertions (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cmdValid,
    input wire mac_pkg::mac_cmd_t cmd,
    input wire logic condTrue,
    input wire logic destShift,
    input wire logic [mac_pkg::ACC_W-1:0] product_accumulator,
    input wire logic [mac_pkg::ACC_W-1:0] shift_result_accumulator,
    input wire logic [mac_pkg::STAT_W-1:0] arith_status_register,
    input wire logic product_acc_overflow_flag,
    input wire logic shift_acc_overflow_flag
);
    timeunit 1ns;
    timeprecision 100ps;
    import mac_pkg::*;
    logic go;
    logic pOvf;
    logic sOvf;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Accepted command and nine-bit overflow test of each accumulator
    assign go = cmdValid && condTrue;
    assign pOvf = !(&product_accumulator[39:31] || !(|product_accumulator[39:31]));
    assign sOvf = !(&shift_result_accumulator[39:31] || !(|shift_result_accumulator[39:31]));
    a_clear_zeroes: assert property (
        go && cmd == CMD_CLEAR && !destShift |=> product_accumulator == '0
        && !product_acc_overflow_flag && !shift_acc_overflow_flag)
        else $error("clear left product data or a flag set");
    a_status_layout: assert property (
        arith_status_register == {7'h00, shift_acc_overflow_flag, 1'b0,
        product_acc_overflow_flag, 6'h00})
        else $error("status word does not carry the flags in place");
    a_product_flag: assert property (
        go && cmd inside {CMD_MUL, CMD_MAC_ADD, CMD_MAC_SUB} && !destShift
        |-> ##1 product_acc_overflow_flag == pOvf && $stable(shift_acc_overflow_flag))
        else $error("product flag does not follow its result");
    a_shift_flag: assert property (
        go && cmd inside {CMD_MUL, CMD_MAC_ADD, CMD_MAC_SUB, CMD_ROUND} && destShift
        |=> shift_acc_overflow_flag == sOvf && $stable(product_acc_overflow_flag))
        else $error("shift flag does not follow its result");
    a_move_flags: assert property (
        go && cmd inside {CMD_MOVE_LOW, CMD_MOVE_MID, CMD_MOVE_TOP, CMD_CLAMP}
        |=> $stable(product_acc_overflow_flag) && $stable(shift_acc_overflow_flag))
        else $error("move or clamp changed a flag");
    a_clamp_pos: assert property (
        go && cmd == CMD_CLAMP && !destShift && pOvf && !product_accumulator[39]
        |=> product_accumulator == 40'h00_7FFF_FFFF)
        else $error("positive clamp value wrong");
    a_clamp_neg: assert property (
        go && cmd == CMD_CLAMP && !destShift && pOvf && product_accumulator[39]
        |=> product_accumulator == 40'hFF_8000_0000)
        else $error("negative clamp value wrong");
    a_clamp_keep: assert property (
        go && cmd == CMD_CLAMP && destShift && !sOvf |=> $stable(shift_result_accumulator))
        else $error("clamp altered a value without overflow");
    a_refuse_hold: assert property (
        !go |=> $stable(product_accumulator) && $stable(shift_result_accumulator))
        else $error("accumulator changed without an accepted command");
endmodule

/* File: verif/operand_regfile.sv */
// Sequencer-side operand register model feeding the restricted sources
module operand_regfile (
    input wire logic mclk,
    input wire logic ldEn,
    input wire logic [2:0] ldIdx,
    input wire logic [15:0] ldData,
    output logic [15:0] xReg0,
    output logic [15:0] xReg1,
    output logic [15:0] yReg0,
    output logic [15:0] yReg1,
    output logic [15:0] aluReg
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] regs [0:4] = '{default: 16'h0000};
    // Load at the edge; the new value is readable only from the next cycle
    always @(posedge mclk) begin
        if (ldEn && ldIdx < 3'h5) begin
            regs[ldIdx] <= ldData;
        end
    end
    // Register contents presented as operand sources
    assign xReg0 = regs[0];
    assign xReg1 = regs[1];
    assign yReg0 = regs[2];
    assign yReg1 = regs[3];
    assign aluReg = regs[4];
endmodule

/* File: verif/tb.sv */
// Self-checking bench of the multiply-accumulate unit
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import mac_pkg::*;
    logic mclk, sysRst, cmdValid, condTrue, destShift, roundEn, fracMode, restrictedForm;
    logic ldEn, pFlag, sFlag, cmdDone, fP, fS;
    mac_cmd_t cmd;
    sign_opt_t signOpt;
    xsrc_t xSel;
    ysrc_t ySel;
    logic [2:0] ldIdx;
    logic [15:0] dregX, dregY, moveData, ldData, xReg0, xReg1, yReg0, yReg1, aluReg, stat, rx;
    logic [39:0] pAcc, sAcc, mP, mS;
    int errCount;
    int compares;
    operand_regfile i_regs (.mclk(mclk), .ldEn(ldEn), .ldIdx(ldIdx), .ldData(ldData),
        .xReg0(xReg0), .xReg1(xReg1), .yReg0(yReg0), .yReg1(yReg1), .aluReg(aluReg));
    mac_unit_result_saturation i_dut (.mclk(mclk), .sys_rst(sysRst), .cmdValid(cmdValid),
        .cmd(cmd), .condTrue(condTrue), .destShift(destShift), .roundEn(roundEn),
        .signOpt(signOpt), .fracMode(fracMode), .restrictedForm(restrictedForm),
        .xSel(xSel), .ySel(ySel), .dregX(dregX), .dregY(dregY), .x_input_reg_0(xReg0),
        .x_input_reg_1(xReg1), .y_input_reg_0(yReg0), .y_input_reg_1(yReg1),
        .alu_result_reg(aluReg), .moveData(moveData), .product_accumulator(pAcc),
        .shift_result_accumulator(sAcc), .arith_status_register(stat),
        .product_acc_overflow_flag(pFlag), .shift_acc_overflow_flag(sFlag), .cmdDone(cmdDone));
    // Free-running core clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(string n, logic [39:0] e, logic [39:0] g);
        compares++;
        if (g !== e) begin
            errCount++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic chkBit(string n, logic e, logic g);
        compares++;
        if (g !== e) begin
            errCount++;
            $display("unexpected %s: expected %b, seen %b", n, e, g);
        end
    endtask
    task automatic cmpAll(logic done);
        chk("productAcc", mP, pAcc);
        chk("shiftAcc", mS, sAcc);
        chkBit("productFlag", fP, pFlag);
        chkBit("shiftFlag", fS, sFlag);
        chk("status", 40'({7'h00, fS, 1'b0, fP, 6'h00}), 40'(stat));
        chkBit("cmdDone", done, cmdDone);
    endtask
    task automatic finishTest();
        $display("checks %0d, mismatches %0d", compares, errCount);
        if (errCount == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic ld(logic [2:0] k, logic [15:0] v);
        cmdValid = 1'b0;
        ldEn = 1'b1;
        ldIdx = k;
        ldData = v;
        @(posedge mclk);
        #1;
    endtask
    // Drive one command, update the reference copy, compare after the edge
    task automatic op(mac_cmd_t c, logic d, logic [15:0] x, logic [15:0] y,
                      logic [15:0] md, logic cnd);
        logic [15:0] xo;
        logic [15:0] yo;
        logic [39:0] a;
        logic signed [16:0] xe;
        logic signed [16:0] ye;
        logic signed [33:0] p;
        logic f;
        cmd = c;
        {destShift, dregX, dregY, moveData, condTrue, cmdValid} = {d, x, y, md, cnd, 1'b1};
        xo = x;
        yo = y;
        if (restrictedForm) begin
            case (xSel)
                XSRC_XIN0: xo = xReg0;
                XSRC_XIN1: xo = xReg1;
                XSRC_ALU: xo = aluReg;
                XSRC_PLOW: xo = mP[15:0];
                XSRC_PMID: xo = mP[31:16];
                XSRC_PTOP: xo = {{8{mP[39]}}, mP[39:32]};
                XSRC_SMID: xo = mS[31:16];
                default: xo = {{8{mS[39]}}, mS[39:32]};
            endcase
            yo = ySel == YSRC_YIN0 ? yReg0 : ySel == YSRC_YIN1 ? yReg1 : ySel == YSRC_SMID ? mS[31:16] : xo;
        end
        xe = {(signOpt == SIGN_SS || signOpt == SIGN_SU) & xo[15], xo};
        ye = {(signOpt == SIGN_SS || signOpt == SIGN_US) & yo[15], yo};
        p = xe * ye;
        a = d ? mS : mP;
        f = d ? fS : fP;
        case (c)
            CMD_MUL: a = {{8{p[31]}}, p[31:0]} << fracMode;
            CMD_MAC_ADD: a = a + ({{8{p[31]}}, p[31:0]} << fracMode);
            CMD_MAC_SUB: a = a - ({{8{p[31]}}, p[31:0]} << fracMode);
            CMD_CLEAR: {a, f} = '0;
            CMD_CLAMP: a = !(&a[39:31] || !(|a[39:31])) ? (a[39] ? 40'hFF_8000_0000 : 40'h00_7FFF_FFFF) : a;
            CMD_MOVE_LOW: a[15:0] = md;
            CMD_MOVE_MID: a[39:16] = {{8{md[15]}}, md};
            CMD_MOVE_TOP: a[39:32] = md[7:0];
            default: a = a;
        endcase
        if (c inside {CMD_MUL, CMD_MAC_ADD, CMD_MAC_SUB, CMD_ROUND}) begin
            a = (fracMode && roundEn) ? (a + 40'h00_0000_8000) & 40'hFF_FFFF_0000 : a;
            f = !(&a[39:31] || !(|a[39:31]));
        end
        if (cnd) begin
            {fP, fS} = c == CMD_CLEAR ? 2'b00 : {fP, fS};
            {mP, fP} = d ? {mP, fP} : {a, f};
            {mS, fS} = d ? {a, f} : {mS, fS};
        end
        @(posedge mclk);
        #1;
        cmpAll(cnd);
    endtask
    // Watchdog cuts a hang short
    initial begin
        #20_000;
        errCount++;
        finishTest();
    end
    initial begin
        {cmdValid, condTrue, destShift, roundEn, fracMode, restrictedForm, ldEn, sysRst} = 8'h01;
        cmd = CMD_NOP;
        signOpt = SIGN_SS;
        xSel = XSRC_XIN0;
        ySel = YSRC_YIN0;
        ldIdx = '0;
        {dregX, dregY, moveData, ldData, mP, mS, fP, fS, errCount, compares} = '0;
        void'($urandom(32'h30f0_fa16));
        repeat (20) @(posedge mclk);
        #1;
        sysRst = 1'b0;
        @(posedge mclk);
        #1;
        cmpAll(1'b0);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            fracMode = i[2];
            signOpt = sign_opt_t'(i[1:0]);
            op(CMD_MUL, i[0], i[2] ? 16'h4000 : 16'h8000, i[2] ? 16'hC000 : 16'h8001, 16'h0000, 1'b1);
        end
        $display("test sign options done");
        fracMode = 1'b0;
        signOpt = SIGN_SS;
        for (int d = 0; d < 2; d++) begin
            op(CMD_CLEAR, d[0], 16'h0000, 16'h0000, 16'h0000, 1'b1);
            op(CMD_MOVE_MID, d[0], 16'h0000, 16'h0000, 16'h1234, 1'b1);
            op(CMD_MOVE_TOP, d[0], 16'h0000, 16'h0000, 16'h0005, 1'b1);
            op(CMD_MAC_ADD, d[0], 16'h0000, 16'h0000, 16'h0000, 1'b1);
            op(CMD_CLAMP, d[0], 16'h0000, 16'h0000, 16'h0000, 1'b1);
            op(CMD_MAC_ADD, d[0], 16'h0001, 16'h0001, 16'h0000, 1'b1);
            op(CMD_MOVE_TOP, d[0], 16'h0000, 16'h0000, 16'h0080, 1'b1);
            op(CMD_CLAMP, d[0], 16'h0000, 16'h0000, 16'h0000, 1'b1);
            op(CMD_CLAMP, d[0], 16'h0000, 16'h0000, 16'h0000, 1'b1);
            op(CMD_CLEAR, d[0], 16'h0000, 16'h0000, 16'h0000, 1'b0);
        end
        $display("test clamp and refresh done");
        roundEn = 1'b1;
        for (int i = 0; i < 4; i++) begin
            fracMode = i[1];
            op(CMD_MOVE_LOW, 1'b0, 16'h0000, 16'h0000, 16'h8000, 1'b1);
            op(CMD_ROUND, 1'b0, 16'h0000, 16'h0000, 16'h0000, 1'b1);
        end
        $display("test round done");
        {fracMode, roundEn, restrictedForm} = 3'b001;
        for (int k = 0; k < 5; k++) begin
            ld(k[2:0], 16'($urandom));
        end
        ldEn = 1'b0;
        for (int i = 0; i < 8; i++) begin
            xSel = xsrc_t'(i[2:0]);
            ySel = ysrc_t'(i[1:0]);
            op(CMD_MUL, i[0], 16'h0000, 16'h0000, 16'h0000, 1'b1);
        end
        $display("test operand sources done");
        for (int i = 0; i < 80; i++) begin
            signOpt = sign_opt_t'($urandom_range(0, 3));
            {fracMode, roundEn} = 2'($urandom);
            xSel = xsrc_t'($urandom_range(0, 7));
            ySel = ysrc_t'($urandom_range(0, 3));
            restrictedForm = signOpt != SIGN_UU && $urandom_range(0, 1) == 1;
            rx = 16'($urandom) & (signOpt == SIGN_UU ? 16'h7FFF : 16'hFFFF);
            op(mac_cmd_t'($urandom_range(0, 9)), $urandom_range(0, 1) == 1, rx, 16'($urandom),
               16'($urandom), $urandom_range(0, 3) != 0);
        end
        $display("test random done");
        cmdValid = 1'b0;
        finishTest();
    end
endmodule
bind mac_unit_result_saturation mac_unit_result_saturation_assertions i_chk (.mclk(mclk),
    .sys_rst(sys_rst), .cmdValid(cmdValid), .cmd(cmd), .condTrue(condTrue),
    .destShift(destShift), .product_accumulator(product_accumulator),
    .shift_result_accumulator(shift_result_accumulator),
    .arith_status_register(arith_status_register),
    .product_acc_overflow_flag(product_acc_overflow_flag),
    .shift_acc_overflow_flag(shift_acc_overflow_flag));
